// file: src/fast_reset_sequencer.sv
// Timed alternate processor reset sequence
`timescale 1ns/1ns
module fast_reset_sequencer
    import sys_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    output logic resetPulse,
    output logic busy
);

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_WAIT = 4'b0010,
        SEQ_PULSE = 4'b0100,
        SEQ_HOLD = 4'b1000
    } seq_state_t;

    localparam logic [SEQ_COUNT_W-1:0] DELAY_LAST = SEQ_COUNT_W'(DELAY_CYCLES - 1);
    localparam logic [SEQ_COUNT_W-1:0] PULSE_LAST = SEQ_COUNT_W'(DELAY_CYCLES + PULSE_CYCLES - 1);
    localparam logic [SEQ_COUNT_W-1:0] SEQ_LAST = SEQ_COUNT_W'(SEQUENCE_CYCLES - 1);

    seq_state_t state_q, state_d;
    logic [SEQ_COUNT_W-1:0] count_q, count_d;
    logic resetPulse_q, resetPulse_d;

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    // Count runs from the write; the pulse starts only after the minimum delay
    always_comb
    begin
        state_d = state_q;
        count_d = count_q + SEQ_COUNT_W'(1);
        resetPulse_d = 1'b0;
        case (state_q)
            SEQ_IDLE:
            begin
                count_d = '0;
                if (start)
                begin
                    state_d = SEQ_WAIT;
                end
            end
            SEQ_WAIT:
            begin
                if (count_q == DELAY_LAST)
                begin
                    state_d = SEQ_PULSE;
                    resetPulse_d = 1'b1;
                end
            end
            SEQ_PULSE:
            begin
                resetPulse_d = 1'b1;
                if (count_q == PULSE_LAST)
                begin
                    state_d = SEQ_HOLD;
                    resetPulse_d = 1'b0;
                end
            end
            SEQ_HOLD:
            begin
                if (count_q == SEQ_LAST)
                begin
                    state_d = SEQ_IDLE;
                end
            end
            default:
            begin
                state_d = SEQ_IDLE;
                count_d = '0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= SEQ_IDLE;
            count_q <= '0;
            resetPulse_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            resetPulse_q <= resetPulse_d;
        end
    end

    assign resetPulse = resetPulse_q;
    assign busy = (state_q != SEQ_IDLE);

endmodule

// file: src/sys_ctrl_pkg.sv
// Constants and carrier types for the system control ports
package sys_ctrl_pkg;

    // ----------------------------------------
    // Port addresses
    // ----------------------------------------
    localparam logic [15:0] SYSTEM_CONTROL_B_ADDR = 16'h0061;
    localparam logic [15:0] SYSTEM_CONTROL_A_ADDR = 16'h0092;

    // ----------------------------------------
    // Field positions, first port
    // ----------------------------------------
    localparam int B_IRQ0_CLR_BIT = 7;
    localparam int B_PARITY_BIT = 7;
    localparam int B_CHANNEL_BIT = 6;
    localparam int B_TIMER2_OUT_BIT = 5;
    localparam int B_REFRESH_BIT = 4;
    localparam int B_CHAN_EN_N_BIT = 3;
    localparam int B_PAR_EN_N_BIT = 2;
    localparam int B_SPEAKER_BIT = 1;
    localparam int B_GATE2_BIT = 0;

    // ----------------------------------------
    // Field positions, second port
    // ----------------------------------------
    localparam int A_LIGHT_HI_BIT = 7;
    localparam int A_LIGHT_LO_BIT = 6;
    localparam int A_WATCHDOG_BIT = 4;
    localparam int A_LOCK_BIT = 3;
    localparam int A_ADDR20_BIT = 1;
    localparam int A_FAST_RESET_BIT = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] B_CTRL_RESET = 4'hc;
    localparam logic [1:0] A_LIGHT_RESET = 2'h0;
    localparam logic A_ADDR20_RESET = 1'b0;
    localparam logic A_FAST_RESET_RESET = 1'b0;
    localparam logic A_LOCK_RESET = 1'b0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int RESET_PULSE_MIN_NS = 100;
    localparam int RESET_PULSE_MAX_NS = 125;
    localparam int RESET_DELAY_MIN_NS = 6720;
    localparam int RESET_SEQUENCE_NS = 13400;
    localparam int PULSE_CYCLES = (RESET_PULSE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DELAY_CYCLES = (RESET_DELAY_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SEQUENCE_CYCLES = RESET_SEQUENCE_NS / CLOCK_PERIOD_NS;
    localparam int SEQ_COUNT_W = 12;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } io_req_t;

    typedef struct packed {
        logic timer0Out;
        logic timer2Out;
        logic refreshReq;
        logic parityErr;
        logic channelCheck;
        logic channelTimeout;
        logic watchdogTimeout;
        logic nmiMask;
        logic passwordInstalled;
        logic passwordHit;
    } board_events_t;

endpackage

// file: src/system_control_ports.sv
// Two byte-wide system control ports reached by processor I/O cycles
// ----------------------------------------
// Behaviour
// - Write bit 7 one clears timer-0 latch
// - First port bit 7 reads parity latch
// - First port bit 6 reads channel latch
// - First port bit 5 reads timer 2 output
// - First port bit 4 toggles per refresh
// - Bit 3 low enables channel check, resets high
// - Bit 2 low enables parity, resets high
// - Bit 1 enables speaker data, resets low
// - Bit 0 drives timer 2 gate
// - Disk light lit when bit 7 or 6
// - Second port bit 4 reads watchdog time-out
// - Lock bit clears only at power-up
// - Lock blocks password bytes when installed
// - Bit 1 gates address bit twenty
// - Fast reset bit cleared by reset, write
// - Rising fast reset write pulses reset output when sequencer idle
// - Reset after 6.72 us, sequence 13.4 us
// - Fast reset bit stays through processor reset
// - NMI on parity, channel, time-outs, watchdog
// - Mask gates only parity and channel check
// ----------------------------------------
`timescale 1ns/1ns
module system_control_ports
    import sys_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic powerOnRst_n,
    input wire io_req_t ioReq,
    input wire board_events_t events,
    output logic [7:0] ioRdData,
    output logic ioRdValid,
    output logic irq0,
    output logic nmi,
    output logic timer2Gate,
    output logic speakerOut,
    output logic diskLight,
    output logic addressBitTwentyGate,
    output logic altProcReset,
    output logic passwordBlock
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic hitB, hitA;
    logic wrB, wrA, rdHit;

    assign hitB = (ioReq.addr == SYSTEM_CONTROL_B_ADDR);
    assign hitA = (ioReq.addr == SYSTEM_CONTROL_A_ADDR);
    assign wrB = ioReq.wr && hitB;
    assign wrA = ioReq.wr && hitA;
    assign rdHit = ioReq.rd && (hitA || hitB);

    // ----------------------------------------
    // First port state
    // ----------------------------------------
    logic [3:0] ctrlB_q, ctrlB_d;
    logic irq0_q, irq0_d;
    logic timer0Prev_q, timer0Prev_d;
    logic parity_q, parity_d;
    logic channel_q, channel_d;
    logic refreshToggle_q, refreshToggle_d;
    logic timer2_q, timer2_d;
    logic speaker_q, speaker_d;

    always_comb
    begin
        ctrlB_d = ctrlB_q;
        if (wrB)
        begin
            ctrlB_d = ioReq.data[3:0];
        end
        timer0Prev_d = events.timer0Out;
        irq0_d = irq0_q;
        if (wrB && ioReq.data[B_IRQ0_CLR_BIT])
        begin
            irq0_d = 1'b0;
        end
        // A new timer edge in the clearing cycle is kept
        if (events.timer0Out && !timer0Prev_q)
        begin
            irq0_d = 1'b1;
        end
        // Disabling a check also drops its latch, the usual way to clear it
        parity_d = parity_q;
        if (ctrlB_q[B_PAR_EN_N_BIT])
        begin
            parity_d = 1'b0;
        end
        if (events.parityErr && !ctrlB_q[B_PAR_EN_N_BIT])
        begin
            parity_d = 1'b1;
        end
        channel_d = channel_q;
        if (ctrlB_q[B_CHAN_EN_N_BIT])
        begin
            channel_d = 1'b0;
        end
        if (events.channelCheck && !ctrlB_q[B_CHAN_EN_N_BIT])
        begin
            channel_d = 1'b1;
        end
        refreshToggle_d = refreshToggle_q ^ events.refreshReq;
        timer2_d = events.timer2Out;
        speaker_d = events.timer2Out && ctrlB_q[B_SPEAKER_BIT];
    end

    always_ff @(posedge clock)
    begin
        if (!powerOnRst_n)
        begin
            ctrlB_q <= B_CTRL_RESET;
        end
        else
        begin
            ctrlB_q <= ctrlB_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            irq0_q <= 1'b0;
            timer0Prev_q <= 1'b0;
            parity_q <= 1'b0;
            channel_q <= 1'b0;
            refreshToggle_q <= 1'b0;
            timer2_q <= 1'b0;
            speaker_q <= 1'b0;
        end
        else
        begin
            irq0_q <= irq0_d;
            timer0Prev_q <= timer0Prev_d;
            parity_q <= parity_d;
            channel_q <= channel_d;
            refreshToggle_q <= refreshToggle_d;
            timer2_q <= timer2_d;
            speaker_q <= speaker_d;
        end
    end

    // ----------------------------------------
    // Second port state
    // ----------------------------------------
    logic [1:0] light_q, light_d;
    logic diskLight_q, diskLight_d;
    logic watchdog_q, watchdog_d;
    logic lock_q, lock_d;
    logic addr20_q, addr20_d;
    logic fastReset_q, fastReset_d;
    logic seqStart;
    logic seqPulse;
    logic altReset_q;
    logic block_q, block_d;

    always_comb
    begin
        light_d = light_q;
        addr20_d = addr20_q;
        fastReset_d = fastReset_q;
        lock_d = lock_q;
        if (wrA)
        begin
            light_d = ioReq.data[A_LIGHT_HI_BIT:A_LIGHT_LO_BIT];
            addr20_d = ioReq.data[A_ADDR20_BIT];
            fastReset_d = ioReq.data[A_FAST_RESET_BIT];
            if (ioReq.data[A_LOCK_BIT])
            begin
                lock_d = 1'b1;
            end
        end
        diskLight_d = light_d[1] || light_d[0];
        watchdog_d = watchdog_q || events.watchdogTimeout;
        block_d = lock_q && events.passwordInstalled && events.passwordHit;
    end

    // Only a 0 to 1 change fires; rewriting 1 does nothing
    assign seqStart = wrA && ioReq.data[A_FAST_RESET_BIT] && !fastReset_q;

    always_ff @(posedge clock)
    begin
        if (!powerOnRst_n)
        begin
            light_q <= A_LIGHT_RESET;
            diskLight_q <= 1'b0;
        end
        else
        begin
            light_q <= light_d;
            diskLight_q <= diskLight_d;
        end
    end

    // The lock follows only power-up, never system reset
    always_ff @(posedge clock)
    begin
        if (!powerOnRst_n)
        begin
            lock_q <= A_LOCK_RESET;
        end
        else
        begin
            lock_q <= lock_d;
        end
    end

    // The processor reset pulse does not reach rst_n, so the bit survives it
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            addr20_q <= A_ADDR20_RESET;
            fastReset_q <= A_FAST_RESET_RESET;
            watchdog_q <= 1'b0;
            block_q <= 1'b0;
            altReset_q <= 1'b0;
        end
        else
        begin
            addr20_q <= addr20_d;
            fastReset_q <= fastReset_d;
            watchdog_q <= watchdog_d;
            block_q <= block_d;
            altReset_q <= seqPulse;
        end
    end

    fast_reset_sequencer resetSeq (
        .clock(clock),
        .rst_n(rst_n),
        .start(seqStart),
        .resetPulse(seqPulse),
        .busy()
    );

    // ----------------------------------------
    // Nonmaskable interrupt
    // ----------------------------------------
    logic nmi_q, nmi_d;

    always_comb
    begin
        nmi_d = ((parity_q || channel_q) && !events.nmiMask)
            || events.channelTimeout || watchdog_q;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            nmi_q <= 1'b0;
        end
        else
        begin
            nmi_q <= nmi_d;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] rdData_q, rdData_d;
    logic rdValid_q, rdValid_d;
    logic [7:0] portB, portA;

    always_comb
    begin
        portB = 8'h00;
        portB[B_PARITY_BIT] = parity_q;
        portB[B_CHANNEL_BIT] = channel_q;
        portB[B_TIMER2_OUT_BIT] = timer2_q;
        portB[B_REFRESH_BIT] = refreshToggle_q;
        portB[3:0] = ctrlB_q;
        portA = 8'h00;
        portA[A_LIGHT_HI_BIT:A_LIGHT_LO_BIT] = light_q;
        portA[A_WATCHDOG_BIT] = watchdog_q;
        portA[A_LOCK_BIT] = lock_q;
        portA[A_ADDR20_BIT] = addr20_q;
        portA[A_FAST_RESET_BIT] = fastReset_q;
        rdValid_d = rdHit;
        rdData_d = rdData_q;
        if (ioReq.rd && hitB)
        begin
            rdData_d = portB;
        end
        else if (ioReq.rd && hitA)
        begin
            rdData_d = portA;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ioRdData = rdData_q;
    assign ioRdValid = rdValid_q;
    assign irq0 = irq0_q;
    assign nmi = nmi_q;
    assign timer2Gate = ctrlB_q[B_GATE2_BIT];
    assign speakerOut = speaker_q;
    assign diskLight = diskLight_q;
    assign addressBitTwentyGate = addr20_q;
    assign altProcReset = altReset_q;
    assign passwordBlock = block_q;

endmodule

// file: tb/system_control_ports_properties.sv
// Checker for the system control ports, bound to the top module
`timescale 1ns/1ns
module system_control_ports_checker
    import sys_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire io_req_t ioReq,
    input wire board_events_t events,
    input wire logic [7:0] ioRdData,
    input wire logic ioRdValid,
    input wire logic irq0,
    input wire logic nmi,
    input wire logic speakerOut,
    input wire logic diskLight,
    input wire logic addressBitTwentyGate,
    input wire logic altProcReset,
    input wire logic passwordBlock
);
    logic wrA, rdB;
    logic [5:0] highCnt_q, highCnt_d;
    logic [15:0] sinceWr_q, sinceWr_d;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    assign wrA = ioReq.wr && ioReq.addr == SYSTEM_CONTROL_A_ADDR;
    assign rdB = ioReq.rd && ioReq.addr == SYSTEM_CONTROL_B_ADDR;

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    // Saturates so a long idle stretch cannot wrap into a false short delay
    always_comb
    begin
        highCnt_d = altProcReset ? highCnt_q + 6'h01 : 6'h00;
        sinceWr_d = (wrA && ioReq.data[0]) ? 16'h0000 : sinceWr_q + {15'h0000, ~&sinceWr_q};
    end

    always_ff @(posedge clock)
    begin
        highCnt_q <= rst_n ? highCnt_d : 6'h00;
        sinceWr_q <= rst_n ? sinceWr_d : 16'hffff;
    end

    chk_read_answer: assert property (
        (rdB || (ioReq.rd && ioReq.addr == SYSTEM_CONTROL_A_ADDR)) |=> ioRdValid)
        else $error("Mapped read gave no answer");
    chk_timer2_read: assert property (
        rdB |=> ioRdData[B_TIMER2_OUT_BIT] == $past(events.timer2Out, 2))
        else $error("Timer 2 level not returned");
    chk_irq_clear: assert property (
        (ioReq.wr && ioReq.addr == SYSTEM_CONTROL_B_ADDR && ioReq.data[B_IRQ0_CLR_BIT]
            && $stable(events.timer0Out)) |=> !irq0)
        else $error("Timer 0 latch not cleared");
    chk_light_follow: assert property (
        wrA |=> diskLight == $past(|ioReq.data[A_LIGHT_HI_BIT:A_LIGHT_LO_BIT]))
        else $error("Disk light wrong");
    chk_gate_follow: assert property (
        wrA |=> addressBitTwentyGate == $past(ioReq.data[A_ADDR20_BIT]))
        else $error("Address gate wrong");
    chk_pulse_width: assert property (
        $fell(altProcReset) |-> highCnt_q >= PULSE_CYCLES && highCnt_q <= 31)
        else $error("Reset pulse width wrong");
    chk_reset_delay: assert property (
        $rose(altProcReset) |-> sinceWr_q >= DELAY_CYCLES && sinceWr_q <= SEQUENCE_CYCLES)
        else $error("Reset pulse delay wrong");
    chk_watchdog_nmi: assert property (
        events.watchdogTimeout |-> ##[1:2] nmi)
        else $error("Watchdog did not raise nmi");
    chk_block_cause: assert property (
        passwordBlock |-> $past(events.passwordHit) && $past(events.passwordInstalled))
        else $error("Password block without cause");
    chk_speaker_gate: assert property (
        speakerOut |-> $past(events.timer2Out))
        else $error("Speaker data without timer 2");

    cover property ($rose(altProcReset));
    cover property (rdB ##1 ioRdData[B_PARITY_BIT]);
    cover property (passwordBlock);
endmodule

bind system_control_ports system_control_ports_checker u_checker (.*);

// file: tb/system_control_ports_tb.sv
// Self-checking testbench for the system control ports
`timescale 1ns/1ns
module system_control_ports_tb;
    import sys_ctrl_pkg::*;
    localparam logic [15:0] PB = SYSTEM_CONTROL_B_ADDR;
    localparam logic [15:0] PA = SYSTEM_CONTROL_A_ADDR;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic powerOnRst_n = 1'b0;
    io_req_t ioReq = '0;
    board_events_t events = '0;
    logic [7:0] ioRdData;
    logic ioRdValid, irq0, nmi, timer2Gate, speakerOut, diskLight;
    logic addressBitTwentyGate, altProcReset, passwordBlock;
    logic [7:0] expQ[$];
    logic [31:0] seed = 32'h0000001c;
    logic [7:0] d;
    logic [7:0] regA = 8'h00;
    logic [3:0] ctrlB = 4'hc;
    logic parL = 1'b0, chanL = 1'b0, toggle = 1'b0;
    int bad_count = 0, tests_run = 0, span;

    always #2 clock = ~clock;

    system_control_ports u_dut (.*);

    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function automatic logic [7:0] expB();
        return {parL, chanL, events.timer2Out, toggle, ctrlB};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Strobes drop at the next falling edge, so each access is one cycle
    task automatic access(input logic isRd, input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock);
        ioReq.rd = isRd;
        ioReq.wr = !isRd;
        ioReq.addr = addr;
        ioReq.data = data;
        @(negedge clock);
        ioReq.rd = 1'b0;
        ioReq.wr = 1'b0;
    endtask

    task automatic readExp(input logic [15:0] addr, input logic [7:0] exp);
        expQ.push_back(exp);
        access(1'b1, addr, 8'h00);
    endtask

    task automatic pulse(input int which);
        @(negedge clock);
        events[which] = 1'b1;
        @(negedge clock);
        events[which] = 1'b0;
    endtask

    always @(negedge clock)
    begin
        if (ioRdValid === 1'b1)
        begin
            if (expQ.size() == 0)
                check(32'h1, 32'h0);
            else
                check(ioRdData, expQ.pop_front());
        end
    end

    initial
    begin
        #120000;
        bad_count++;
        final_report();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        powerOnRst_n = 1'b1;
        readExp(PB, expB());
        readExp(PA, 8'h00);
        access(1'b1, 16'h0060, 8'h00);
        repeat (6)
        begin
            d = rnd();
            access(1'b0, PB, d);
            ctrlB = d[3:0];
            events.timer2Out = d[5];
            @(negedge clock);
            check(timer2Gate, d[0]);
            check(speakerOut, d[1] & d[5]);
            readExp(PB, expB());
            d = rnd() & 8'hf6;
            access(1'b0, PA, d);
            regA = d & 8'hc2;
            @(negedge clock);
            check(diskLight, |d[7:6]);
            check(addressBitTwentyGate, d[1]);
            readExp(PA, regA);
        end
        repeat (3)
        begin
            pulse(7);
            toggle = ~toggle;
            readExp(PB, expB());
        end
        events.timer0Out = 1'b1;
        repeat (2) @(negedge clock);
        check(irq0, 1'b1);
        access(1'b0, PB, {4'h8, ctrlB});
        @(negedge clock);
        check(irq0, 1'b0);
        access(1'b0, PB, 8'h00);
        ctrlB = 4'h0;
        events.nmiMask = 1'b1;
        pulse(6);
        pulse(5);
        parL = 1'b1;
        chanL = 1'b1;
        @(negedge clock);
        check(nmi, 1'b0);
        readExp(PB, expB());
        events.nmiMask = 1'b0;
        repeat (2) @(negedge clock);
        check(nmi, 1'b1);
        pulse(3);
        regA[4] = 1'b1;
        readExp(PA, regA);
        access(1'b0, PB, 8'h0c);
        ctrlB = 4'hc;
        parL = 1'b0;
        chanL = 1'b0;
        @(negedge clock);
        readExp(PB, expB());
        access(1'b0, PA, regA | 8'h01);
        regA[0] = 1'b1;
        span = 0;
        while (altProcReset !== 1'b1 && span < 4000)
        begin
            @(negedge clock);
            span++;
        end
        check(span >= DELAY_CYCLES && span <= SEQUENCE_CYCLES, 1'b1);
        span = 0;
        while (altProcReset === 1'b1 && span < 100)
        begin
            @(negedge clock);
            span++;
        end
        check(span >= PULSE_CYCLES && span <= RESET_PULSE_MAX_NS / CLOCK_PERIOD_NS, 1'b1);
        readExp(PA, regA);
        repeat (SEQUENCE_CYCLES) @(negedge clock);
        access(1'b0, PA, regA);
        span = 0;
        repeat (SEQUENCE_CYCLES)
        begin
            @(negedge clock);
            if (altProcReset !== 1'b0)
                span++;
        end
        check(span, 0);
        regA[0] = 1'b0;
        access(1'b0, PA, regA);
        readExp(PA, regA);
        access(1'b0, PA, 8'h0a);
        events.passwordInstalled = 1'b1;
        events.passwordHit = 1'b1;
        access(1'b0, PA, 8'h00);
        check(passwordBlock, 1'b1);
        readExp(PA, 8'h18);
        events.passwordInstalled = 1'b0;
        repeat (2) @(negedge clock);
        check(passwordBlock, 1'b0);
        access(1'b0, PA, 8'h03);
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        readExp(PA, 8'h08);
        @(negedge clock);
        rst_n = 1'b0;
        powerOnRst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        powerOnRst_n = 1'b1;
        readExp(PA, 8'h00);
        events.nmiMask = 1'b1;
        events.channelTimeout = 1'b1;
        repeat (2) @(negedge clock);
        check(nmi, 1'b1);
        events.channelTimeout = 1'b0;
        repeat (3) @(negedge clock);
        check(expQ.size(), 0);
        final_report();
    end
endmodule
